// >>> logic/sds_status_events.sv
`timescale 1ns/1ns
module sds_status_events
  import sds_pkg::*;
#(
  parameter int TICK_CYCLES = sds_pkg::TICK_CYCLES_DEF,
  parameter int SDCLK_HALF  = sds_pkg::SDCLK_HALF_DEF
) (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        CARD_DET_N_I,
  input  wire logic        RESP_DONE_I,
  input  wire logic        PROTO_ERR_I,
  input  wire logic        DATA_ACTIVE_I,
  output logic             SD_CLK_O,
  output logic             STOP_CMD_O,
  output logic             IRQ_O
);
  import sds_pkg::*;

  // ============================================================
  // Parameter checks
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
  begin : g_chk_tick
    $error("TICK_CYCLES out of range");
  end
  if (SDCLK_HALF < 1 || SDCLK_HALF > 255)
  begin : g_chk_half
    $error("SDCLK_HALF out of range");
  end

  localparam int NIB_W = $clog2(NIBBLES_PER_BLOCK);
  localparam logic [15:0]      TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [7:0]       HALF_LAST = 8'(SDCLK_HALF - 1);
  localparam logic [NIB_W-1:0] NIB_LAST  = NIB_W'(NIBBLES_PER_BLOCK - 1);

  // ============================================================
  // State
  sds_op_t          state_q,     state_d;
  logic             mode_irq_q,  mode_irq_d;
  logic             cd_irq_q,    cd_irq_d;
  logic             tran_q,      tran_d;
  logic [7:0]       tmo_ms_q,    tmo_ms_d;
  logic [15:0]      blk_req_q,   blk_req_d;
  logic [15:0]      blk_left_q,  blk_left_d;
  logic [3:1]       sta_a_q,     sta_a_d;
  logic [3:0]       sta_b_q,     sta_b_d;
  logic [3:0]       mask_a_q,    mask_a_d;
  logic [3:0]       mask_b_q,    mask_b_d;
  logic [3:0]       snap_a_q,    snap_a_d;
  logic [3:0]       snap_b_q,    snap_b_d;
  logic [7:0]       half_cnt_q,  half_cnt_d;
  logic             sd_clk_q,    sd_clk_d;
  logic [NIB_W-1:0] nib_cnt_q,   nib_cnt_d;
  logic             resp_seen_q, resp_seen_d;
  logic [15:0]      tick_cnt_q,  tick_cnt_d;
  logic [7:0]       ms_cnt_q,    ms_cnt_d;
  logic             stop_q,      stop_d;
  logic             irq_q,       irq_d;
  logic             cd_prev_q,   cd_prev_d;
  logic [31:0]      hrdata_q,    hrdata_d;
  logic             wr_pend_q,   wr_pend_d;
  logic [7:0]       wr_addr_q,   wr_addr_d;

  logic cd_s;
  logic present;
  logic running;
  logic tick;
  logic toggle;
  logic sd_rise;
  logic blk_evt;
  logic ins_evt;
  logic rem_evt;
  logic resp_evt;
  logic perr_evt;
  logic tmo_evt;
  logic err;
  logic start_wr;
  logic acc;
  logic [3:0] clr_a;
  logic [3:0] clr_b;
  logic [3:0] live_a;

  // ============================================================
  // Card detect pin synchroniser, no card during reset
  sds_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_cd_sync (
    .clk_i   (CLK_I),
    .rstn_i  (RSTN_I),
    .async_i (CARD_DET_N_I),
    .sync_o  (cd_s)
  );

  // ============================================================
  // Next-state logic
  always_comb
  begin
    state_d     = state_q;
    mode_irq_d  = mode_irq_q;
    cd_irq_d    = cd_irq_q;
    tran_d      = tran_q;
    tmo_ms_d    = tmo_ms_q;
    blk_req_d   = blk_req_q;
    blk_left_d  = blk_left_q;
    mask_a_d    = mask_a_q;
    mask_b_d    = mask_b_q;
    snap_a_d    = snap_a_q;
    snap_b_d    = snap_b_q;
    resp_seen_d = resp_seen_q;
    ms_cnt_d    = ms_cnt_q;
    stop_d      = 1'b0;
    hrdata_d    = hrdata_q;
    cd_prev_d   = cd_s;
    clr_a       = 4'h0;
    clr_b       = 4'h0;
    start_wr    = 1'b0;

    // Free-running 1 ms tick
    tick       = (tick_cnt_q == TICK_LAST);
    tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;

    // Card clock divider, gated by the operation
    running  = (state_q != SDS_IDLE);
    toggle   = running && (half_cnt_q == HALF_LAST);
    sd_rise  = toggle && !sd_clk_q;
    if (running)
    begin
      half_cnt_d = toggle ? 8'h00 : half_cnt_q + 8'h01;
      sd_clk_d   = toggle ? !sd_clk_q : sd_clk_q;
    end
    else
    begin
      half_cnt_d = 8'h00;
      sd_clk_d   = 1'b0;
    end

    // Data nibble counter, one block per 512 bytes
    blk_evt   = 1'b0;
    nib_cnt_d = nib_cnt_q;
    if (running && DATA_ACTIVE_I && sd_rise)
    begin
      if (nib_cnt_q == NIB_LAST)
      begin
        nib_cnt_d = '0;
        blk_evt   = 1'b1;
      end
      else
      begin
        nib_cnt_d = nib_cnt_q + NIB_W'(1);
      end
    end

    // Card and protocol events
    present  = !cd_s;
    ins_evt  = cd_prev_q && !cd_s;
    rem_evt  = !cd_prev_q && cd_s;
    resp_evt = running && RESP_DONE_I;
    perr_evt = running && PROTO_ERR_I;
    tmo_evt  = running && tick && (tmo_ms_q != 8'h00)
               && (ms_cnt_q == tmo_ms_q - 8'h01);
    err      = perr_evt || tmo_evt;

    // Wait timer restarts on each card response and each completed data block
    if (!running || resp_evt || blk_evt || tmo_evt)
    begin
      ms_cnt_d = 8'h00;
    end
    else if (tick)
    begin
      ms_cnt_d = ms_cnt_q + 8'h01;
    end

    // Bus address phase
    acc       = HSEL_I && HTRANS_I[1] && HREADY_I;
    wr_pend_d = acc && HWRITE_I;
    wr_addr_d = acc ? HADDR_I[7:0] : wr_addr_q;
    live_a    = {sta_a_q, present};
    if (acc && !HWRITE_I)
    begin
      case (HADDR_I[7:0])
        OFF_CTRL:   hrdata_d = {blk_req_q, tmo_ms_q, 4'h0, tran_q, cd_irq_q,
                                mode_irq_q, running};
        OFF_STA_A:  hrdata_d = {28'h0000000, live_a};
        OFF_STA_B:  hrdata_d = {28'h0000000, sta_b_q};
        OFF_MASK_A: hrdata_d = {28'h0000000, mask_a_q};
        OFF_MASK_B: hrdata_d = {28'h0000000, mask_b_q};
        OFF_SNAP_A: hrdata_d = {28'h0000000, snap_a_q};
        OFF_SNAP_B: hrdata_d = {28'h0000000, snap_b_q};
        OFF_BLKS:   hrdata_d = {16'h0000, blk_left_q};
        default:    hrdata_d = 32'h00000000;
      endcase
    end

    // Bus data phase writes
    if (wr_pend_q)
    begin
      case (wr_addr_q)
        OFF_CTRL:
        begin
          mode_irq_d = HWDATA_I[CTRL_MODE_BIT];
          cd_irq_d   = HWDATA_I[CTRL_CDIRQ_BIT];
          tran_d     = HWDATA_I[CTRL_TRAN_BIT];
          tmo_ms_d   = HWDATA_I[CTRL_TMO_LSB +: 8];
          blk_req_d  = HWDATA_I[CTRL_BLK_LSB +: 16];
          start_wr   = HWDATA_I[CTRL_START_BIT];
        end
        OFF_STA_A:  clr_a    = HWDATA_I[3:0];
        OFF_STA_B:  clr_b    = HWDATA_I[3:0];
        OFF_MASK_A: mask_a_d = HWDATA_I[3:0];
        OFF_MASK_B: mask_b_d = HWDATA_I[3:0];
        default:    clr_a    = 4'h0;
      endcase
    end

    // Operation sequencer
    case (state_q)
      SDS_IDLE:
      begin
        if (start_wr)
        begin
          state_d     = SDS_RUN;
          resp_seen_d = 1'b0;
          blk_left_d  = blk_req_d;
          nib_cnt_d   = '0;
        end
      end
      SDS_RUN:
      begin
        if (blk_evt && blk_left_q != 16'h0000)
        begin
          blk_left_d = blk_left_q - 16'h0001;
        end
        if (resp_evt)
        begin
          resp_seen_d = 1'b1;
        end
        if (err)
        begin
          state_d = tran_q ? SDS_STOP : SDS_IDLE;
          stop_d  = tran_q;
        end
        else if (resp_seen_d && blk_left_d == 16'h0000)
        begin
          state_d = SDS_IDLE;
        end
      end
      SDS_STOP:
      begin
        // Stop response or a further fault ends the operation
        if (resp_evt || err)
        begin
          state_d = SDS_IDLE;
        end
      end
      default:
      begin
        state_d = SDS_IDLE;
      end
    endcase

    // Sticky flags, a set beats a clear in the same cycle
    sta_a_d = (sta_a_q & ~clr_a[3:1]) | {resp_evt, rem_evt, ins_evt};
    sta_b_d = (sta_b_q & ~clr_b) | {stop_d, tmo_evt, perr_evt, blk_evt};

    // Interrupt: card events need card detect irq, protocol needs irq mode
    irq_d = (cd_irq_q && |(sta_a_d[2:1] & mask_a_q[2:1]))
            || (mode_irq_q && sta_a_d[3] && mask_a_q[3])
            || (mode_irq_q && |(sta_b_d & mask_b_q));

    // Snapshot of status on each new interrupt while irq mode is set
    if (mode_irq_q && irq_d && !irq_q)
    begin
      snap_a_d = {sta_a_d, present};
      snap_b_d = sta_b_d;
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      state_q     <= SDS_IDLE;
      mode_irq_q  <= 1'b0;
      cd_irq_q    <= 1'b0;
      tran_q      <= 1'b0;
      tmo_ms_q    <= TMO_MS_RST;
      blk_req_q   <= BLK_RST;
      blk_left_q  <= BLK_RST;
      sta_a_q     <= 3'h0;
      sta_b_q     <= 4'h0;
      mask_a_q    <= MASK_RST;
      mask_b_q    <= MASK_RST;
      snap_a_q    <= 4'h0;
      snap_b_q    <= 4'h0;
      half_cnt_q  <= 8'h00;
      sd_clk_q    <= 1'b0;
      nib_cnt_q   <= '0;
      resp_seen_q <= 1'b0;
      tick_cnt_q  <= 16'h0000;
      ms_cnt_q    <= 8'h00;
      stop_q      <= 1'b0;
      irq_q       <= 1'b0;
      cd_prev_q   <= 1'b1;
      hrdata_q    <= 32'h00000000;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
    end
    else
    begin
      state_q     <= state_d;
      mode_irq_q  <= mode_irq_d;
      cd_irq_q    <= cd_irq_d;
      tran_q      <= tran_d;
      tmo_ms_q    <= tmo_ms_d;
      blk_req_q   <= blk_req_d;
      blk_left_q  <= blk_left_d;
      sta_a_q     <= sta_a_d;
      sta_b_q     <= sta_b_d;
      mask_a_q    <= mask_a_d;
      mask_b_q    <= mask_b_d;
      snap_a_q    <= snap_a_d;
      snap_b_q    <= snap_b_d;
      half_cnt_q  <= half_cnt_d;
      sd_clk_q    <= sd_clk_d;
      nib_cnt_q   <= nib_cnt_d;
      resp_seen_q <= resp_seen_d;
      tick_cnt_q  <= tick_cnt_d;
      ms_cnt_q    <= ms_cnt_d;
      stop_q      <= stop_d;
      irq_q       <= irq_d;
      cd_prev_q   <= cd_prev_d;
      hrdata_q    <= hrdata_d;
      wr_pend_q   <= wr_pend_d;
      wr_addr_q   <= wr_addr_d;
    end
  end

  // ============================================================
  // Outputs from flops or tied constants; bus is zero-wait and always OKAY
  assign HRDATA_O    = hrdata_q;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign SD_CLK_O    = sd_clk_q;
  assign STOP_CMD_O  = stop_q;
  assign IRQ_O       = irq_q;

endmodule

// >>> logic/sds_pkg.sv
// ============================================================
// Shared constants for the card host status and event block
package sds_pkg;

  // ============================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int TICK_PERIOD_NS  = 1000000;
  localparam int TICK_CYCLES_DEF = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SDCLK_HALF_DEF  = 2;

  // ============================================================
  // Data block geometry, 4-bit data bus
  localparam int BLOCK_BYTES       = 512;
  localparam int NIBBLES_PER_BLOCK = BLOCK_BYTES * 2;

  // ============================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STA_A  = 8'h04;
  localparam logic [7:0] OFF_STA_B  = 8'h08;
  localparam logic [7:0] OFF_MASK_A = 8'h0C;
  localparam logic [7:0] OFF_MASK_B = 8'h10;
  localparam logic [7:0] OFF_SNAP_A = 8'h14;
  localparam logic [7:0] OFF_SNAP_B = 8'h18;
  localparam logic [7:0] OFF_BLKS   = 8'h1C;

  // ============================================================
  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_BIT  = 1;
  localparam int CTRL_CDIRQ_BIT = 2;
  localparam int CTRL_TRAN_BIT  = 3;
  localparam int CTRL_TMO_LSB   = 8;
  localparam int CTRL_BLK_LSB   = 16;

  // ============================================================
  // Status register A and B fields
  localparam int A_PRESENT_BIT = 0;
  localparam int A_INSERT_BIT  = 1;
  localparam int A_REMOVE_BIT  = 2;
  localparam int A_RESP_BIT    = 3;
  localparam int B_DREQ_BIT    = 0;
  localparam int B_PERR_BIT    = 1;
  localparam int B_TMO_BIT     = 2;
  localparam int B_STOP_BIT    = 3;

  // ============================================================
  // Reset values
  localparam logic [7:0]  TMO_MS_RST = 8'h64;
  localparam logic [15:0] BLK_RST    = 16'h0000;
  localparam logic [3:0]  MASK_RST   = 4'h0;

  // Operation sequencer states
  typedef enum logic [1:0] {SDS_IDLE, SDS_RUN, SDS_STOP} sds_op_t;

endpackage

// >>> logic/sds_sync.sv
`timescale 1ns/1ns
// ============================================================
// Two-flop synchroniser for levels from outside the clock domain
module sds_sync #(
  parameter int         WIDTH   = 1,
  parameter logic [0:0] RST_VAL = 1'b0
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= {WIDTH{RST_VAL}};
      sync_q <= {WIDTH{RST_VAL}};
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// >>> test/sds_monitor.sv
`timescale 1ns/1ns
// ========
// Port checker for the card host status block
module sds_monitor
  import sds_pkg::*;
#(
  parameter int SDCLK_HALF = 2
) (
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        CARD_DET_N_I,
  input wire logic        SD_CLK_O,
  input wire logic        STOP_CMD_O,
  input wire logic        IRQ_O
);
  logic       rd_go;
  logic       wr_go;
  logic [7:0] hi_d;
  logic [7:0] hi_q;
  // Taken bus requests
  assign rd_go = HSEL_I & HTRANS_I[1] & HREADY_I & !HWRITE_I;
  assign wr_go = HSEL_I & HTRANS_I[1] & HREADY_I & HWRITE_I;
  // Length of the current card clock high phase
  always_comb hi_d = SD_CLK_O ? hi_q + 8'h01 : 8'h00;
  always_ff @(posedge CLK_I) hi_q <= RSTN_I ? hi_d : 8'h00;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // ========
  // Assertions
  chk_bus_ready: assert property (HREADYOUT_O)
    else $error("bus ready dropped");
  chk_bus_okay: assert property (!HRESP_O)
    else $error("bus response not okay");
  chk_unmapped_zero: assert property (rd_go && HADDR_I[7:0] >= 8'h20 |=> HRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  chk_live_present: assert property ((!$changed(CARD_DET_N_I))[*4] ##0 rd_go
    && HADDR_I[7:0] == OFF_STA_A |=> HRDATA_O[0] == !$past(CARD_DET_N_I))
    else $error("present bit wrong");
  chk_stop_pulse: assert property (STOP_CMD_O |=> !STOP_CMD_O)
    else $error("stop pulse too long");
  chk_irq_sticky: assert property ($fell(IRQ_O) |-> $past(wr_go, 2) || $past(wr_go, 3))
    else $error("irq fell without write");
  chk_clk_high: assert property (hi_q <= 8'(SDCLK_HALF))
    else $error("card clock high too long");
  chk_clk_low: assert property ($rose(SD_CLK_O) |-> !$past(SD_CLK_O, 2))
    else $error("card clock low too short");
  // Main scenarios
  cov_stop: cover property (STOP_CMD_O);
  cov_irq: cover property ($rose(IRQ_O));
  cov_clk: cover property ($rose(SD_CLK_O));
endmodule

bind sds_status_events sds_monitor #(.SDCLK_HALF(SDCLK_HALF)) sds_monitor_inst (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .CARD_DET_N_I(CARD_DET_N_I),
  .SD_CLK_O(SD_CLK_O), .STOP_CMD_O(STOP_CMD_O), .IRQ_O(IRQ_O));

// >>> test/sds_card_model.sv
`timescale 1ns/1ns
// ========
// Behavioural card on the far side of the host
module sds_card_model (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic stop_i,
  input  wire logic insert_i,
  input  wire logic resp_req_i,
  input  wire logic err_req_i,
  input  wire logic xfer_i,
  output logic      card_det_n_o,
  output logic      resp_done_o,
  output logic      proto_err_o,
  output logic      data_active_o
);
  logic [3:0] ans_q;
  logic [3:0] busy_q;
  // Stop answer delay and busy time after a stop
  always_ff @(posedge clk_i)
  begin
    ans_q <= rstn_i ? {ans_q[2:0], stop_i} : 4'h0;
    busy_q <= !rstn_i ? 4'h0 : ans_q[3] ? 4'hF : busy_q - {3'h0, busy_q != 4'h0};
  end
  // Socket switch low while a card sits in it
  assign card_det_n_o  = !insert_i;
  // A busy card rejects the next command
  assign resp_done_o   = ans_q[3] | (resp_req_i & busy_q == 4'h0);
  assign proto_err_o   = err_req_i | (resp_req_i & busy_q != 4'h0);
  assign data_active_o = xfer_i;
endmodule

// >>> test/tb.sv
`timescale 1ns/1ns
// ========
// Bench for the card host status block
module tb;
  import sds_pkg::*;
  localparam int TCK = 10;
  logic        clk    = 1'b0;
  logic        rstn   = 1'b0;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        ins    = 1'b0;
  logic        rq     = 1'b0;
  logic        eq     = 1'b0;
  logic        xf     = 1'b0;
  logic [31:0] hrdata;
  logic        hrdy, hresp, det_n, rsp, perr, dact, sdclk, stop, irq;
  int          miscompares = 0;
  int          checks_done = 0;

  sds_status_events #(.TICK_CYCLES(TCK), .SDCLK_HALF(4)) sds_status_events_inst (
    .CLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
    .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .CARD_DET_N_I(det_n),
    .RESP_DONE_I(rsp), .PROTO_ERR_I(perr), .DATA_ACTIVE_I(dact), .SD_CLK_O(sdclk),
    .STOP_CMD_O(stop), .IRQ_O(irq));
  sds_card_model sds_card_model_inst (.clk_i(clk), .rstn_i(rstn), .stop_i(stop),
    .insert_i(ins), .resp_req_i(rq), .err_req_i(eq), .xfer_i(xf), .card_det_n_o(det_n),
    .resp_done_o(rsp), .proto_err_o(perr), .data_active_o(dact));

  // 25 MHz clock
  always #20 clk = ~clk;

  // ========
  // Shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(a, 1'b1, d, v);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    @(posedge clk);
    bus(a, 1'b0, 32'h0, v);
    cmp(v, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Wait for the interrupt, counting card clock rises
  task automatic wirq(input int lim, output int rises, output int cnt);
    logic p;
    p = sdclk;
    rises = 0;
    cnt = 0;
    while (irq !== 1'b1 && cnt < lim)
    begin
      @(posedge clk);
      if (sdclk === 1'b1 && p !== 1'b1)
        rises++;
      p = sdclk;
      cnt++;
    end
  endtask
  task automatic pulse_rq;
    rq <= 1'b1;
    @(posedge clk);
    rq <= 1'b0;
  endtask

  // ========
  // Scenarios
  task automatic t_reset;
    cmp(32'(sdclk), 32'h0);
    cmp(32'(hresp), 32'h0);
    cmp(32'(hrdy), 32'h1);
    cmp(32'(stop), 32'h0);
    cmp(32'(irq), 32'h0);
    rdc(OFF_CTRL, 32'h0000_6400);
    rdc(OFF_MASK_B, 32'h0);
    rdc(8'h40, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_detect;
    wr(OFF_MASK_A, 32'h6);
    ins <= 1'b1;
    cyc(6);
    cmp(32'(irq), 32'h0);
    rdc(OFF_STA_A, 32'h3);
    wr(OFF_CTRL, 32'h0000_6404);
    cyc(2);
    cmp(32'(irq), 32'h1);
    wr(OFF_STA_A, 32'h2);
    cyc(2);
    cmp(32'(irq), 32'h0);
    ins <= 1'b0;
    cyc(6);
    rdc(OFF_STA_A, 32'h4);
    cmp(32'(irq), 32'h1);
    wr(OFF_STA_A, 32'h4);
    wr(OFF_CTRL, 32'h0000_6400);
    $display("test detect done");
  endtask
  task automatic t_resp;
    int n;
    int c;
    wr(OFF_MASK_A, 32'h8);
    wr(OFF_CTRL, 32'h0000_6403);
    cyc(2);
    wirq(16, n, c);
    cmp(n, 2);
    pulse_rq();
    cyc(3);
    cmp(32'(irq), 32'h1);
    rdc(OFF_STA_A, 32'h8);
    rdc(OFF_SNAP_A, 32'h8);
    rdc(OFF_CTRL, 32'h0000_6402);
    cmp(32'(sdclk), 32'h0);
    wr(OFF_STA_A, 32'h8);
    wr(OFF_MASK_A, 32'h0);
    $display("test response done");
  endtask
  task automatic t_data;
    int n;
    int c;
    wr(OFF_MASK_B, 32'h1);
    wr(OFF_CTRL, 32'h0001_0003);
    xf <= 1'b1;
    wirq(9000, n, c);
    xf <= 1'b0;
    cmp(32'(n >= 1023 && n <= 1025), 32'h1);
    rdc(OFF_STA_B, 32'h1);
    rdc(OFF_BLKS, 32'h0);
    pulse_rq();
    cyc(4);
    cmp(32'(sdclk), 32'h0);
    wr(OFF_STA_B, 32'h1);
    wr(OFF_STA_A, 32'h8);
    $display("test data done");
  endtask
  task automatic t_err;
    int n;
    wr(OFF_MASK_B, 32'h2);
    wr(OFF_CTRL, 32'h0000_640B);
    cyc(3);
    eq <= 1'b1;
    @(posedge clk);
    eq <= 1'b0;
    n = 0;
    repeat (6)
    begin
      @(posedge clk);
      if (stop === 1'b1)
        n++;
    end
    cmp(n, 1);
    rdc(OFF_STA_B, 32'hA);
    rdc(OFF_CTRL, 32'h0000_640A);
    // Card still busy after the stop rejects the next command
    wr(OFF_STA_B, 32'h2);
    wr(OFF_CTRL, 32'h0000_6403);
    pulse_rq();
    cyc(2);
    rdc(OFF_STA_B, 32'hA);
    rdc(OFF_CTRL, 32'h0000_6402);
    wr(OFF_STA_B, 32'hF);
    wr(OFF_STA_A, 32'hF);
    $display("test error stop done");
  endtask
  task automatic t_tmo;
    int n;
    int c;
    wr(OFF_MASK_B, 32'h4);
    wr(OFF_CTRL, 32'h0000_0203);
    wirq(200, n, c);
    cmp(32'(c >= TCK - 1 && c <= 2 * TCK + 4), 32'h1);
    rdc(OFF_STA_B, 32'h4);
    rdc(OFF_SNAP_B, 32'h4);
    wr(OFF_STA_B, 32'h4);
    cyc(2);
    cmp(32'(irq), 32'h0);
    $display("test timeout done");
  endtask

  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #(40 * 20000);
    miscompares++;
    conclude();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_detect();
    t_resp();
    t_data();
    t_err();
    t_tmo();
    conclude();
  end
endmodule
